// file: design/fsp_ctrl.sv
// flash self-program protection, addressing and command sequencing
// What this block does
// - lock bits only program; chip erase clears
// - general write lock bits have no effect on program stores
// - general read/write lock bits have no effect on loads or stores
// - application field 11 allows everything
// - application field 10 blocks application stores
// - application 00 blocks stores, boot-code loads
// - application 01 allows stores, blocks boot loads
// - application high programmed masks irq conditionally
// - boot 11 free, boot 10 blocks stores
// - boot 00 blocks stores and application loads
// - boot 01 blocks application loads; masks irq in boot code with application vectors
// - bit value 1 unprogrammed, 0 programmed
// - reset vector zero or boot start by fuse
// - fuses change only via programming interface
// - pointer is high byte and low byte
// - low bits word in page, high page
// - address latched when operation starts
// - lock programming ignores the pointer
// - loads use full byte pointer
// - buffer words load in any order
// - store honoured four cycles after enable
// - stores from application code are ignored
`timescale 1ns/1ps
module fsp_ctrl (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [7:0] flash_pointer_high,
   input wire logic [7:0] flash_pointer_low,
   input wire logic ctrl_we,
   input wire fsp_pkg::fsp_op_type ctrl_op,
   input wire logic store_program_memory_instr,
   input wire logic [15:0] store_data,
   input wire logic lpm_strobe,
   input wire logic [fsp_pkg::WORD_ADDR_W-1:0] pc_word,
   input wire logic ivsel_boot,
   input wire logic flash_done,
   input wire logic prog_lock_we,
   input wire logic [7:0] prog_lock_data,
   input wire logic prog_fuse_we,
   input wire logic [7:0] prog_fuse_data,
   input wire logic chip_erase,
   output logic store_enable_bit,
   output fsp_pkg::fsp_flash_cmd_type flash_cmd,
   output logic flash_cmd_valid,
   output logic store_ignored,
   output logic store_denied,
   output logic lpm_valid,
   output logic [fsp_pkg::PTR_W-1:0] lpm_addr,
   output logic lpm_denied,
   output logic irq_mask,
   output logic [fsp_pkg::WORD_ADDR_W-1:0] reset_vector,
   output logic [7:0] lock_bits,
   output logic [7:0] fuse_bits
);
   import fsp_pkg::*;

   fsp_state_type state_q;
   logic [2:0] win_q;
   fsp_op_type op_q;
   logic [PTR_W-1:0] z;
   logic [PAGE_W-1:0] z_page;
   logic [WORD_IDX_W-1:0] z_word;
   logic [PAGE_W-1:0] boot_start;
   logic tgt_boot;
   logic exec_boot;
   logic app_store_ok;
   logic app_read_ok;
   logic app_irq;
   logic boot_store_ok;
   logic boot_read_ok;
   logic boot_irq;
   logic store_take;
   logic flash_op;
   logic store_ok;
   logic read_ok;

   // pointer assembly and page/word split; the word index is Z5:Z1
   assign z = {flash_pointer_high, flash_pointer_low};
   assign z_page = z[PTR_W-1 -: PAGE_W];
   assign z_word = z[WORD_IDX_W:1];

   // boundary from the size fuse code
   always_comb begin
      case (fuse_bits[FUSE_SIZE_HI:FUSE_SIZE_LO])
         2'h0: boot_start = BOOT_START_0;
         2'h1: boot_start = BOOT_START_1;
         2'h2: boot_start = BOOT_START_2;
         default: boot_start = BOOT_START_3;
      endcase
   end

   // section of target and of executing code by page compare
   assign tgt_boot = (z_page >= boot_start);
   assign exec_boot = (pc_word[WORD_ADDR_W-1 -: PAGE_W] >= boot_start);

   fsp_lock_dec u_app_dec (
      .field({lock_bits[LOCK_APP_HI], lock_bits[LOCK_APP_LO]}),
      .store_ok(app_store_ok),
      .cross_read_ok(app_read_ok),
      .irq_gate(app_irq)
   );

   fsp_lock_dec u_boot_dec (
      .field({lock_bits[LOCK_BOOT_HI], lock_bits[LOCK_BOOT_LO]}),
      .store_ok(boot_store_ok),
      .cross_read_ok(boot_read_ok),
      .irq_gate(boot_irq)
   );

   // permissions look only at the section fields, never the general lock
   assign store_ok = tgt_boot ? boot_store_ok : app_store_ok;
   // a load is refused only when it crosses from one section into the other
   assign read_ok = (tgt_boot == exec_boot) || (tgt_boot ? boot_read_ok : app_read_ok);

   // a store counts only inside the window and only from boot code
   assign store_take = (state_q == ST_ARMED) && store_program_memory_instr && exec_boot;
   assign flash_op = (op_q == OP_ERASE) || (op_q == OP_WRITE);

   // enable sequencer: armed by a control write, closed by a store or the window end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         win_q <= 3'h0;
         op_q <= OP_FILL;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (ctrl_we) begin
                  state_q <= ST_ARMED;
                  win_q <= ENABLE_WINDOW;
                  op_q <= ctrl_op;
               end
            end
            ST_ARMED: begin
               if (store_take) begin
                  // refused erase or write simply ends the window
                  state_q <= (flash_op && store_ok) ? ST_BUSY : ST_IDLE;
               end else if (win_q == 3'h1) begin
                  state_q <= ST_IDLE;  // auto-clear when no store came
               end else begin
                  win_q <= win_q - 3'h1;
               end
            end
            ST_BUSY: begin
               if (flash_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // enable bit stays high through the window and the whole erase or write
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         store_enable_bit <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: store_enable_bit <= ctrl_we;
            ST_ARMED: store_enable_bit <= store_take ? (flash_op && store_ok)
                                                   : (win_q != 3'h1);
            ST_BUSY: store_enable_bit <= !flash_done;
            default: store_enable_bit <= 1'b0;
         endcase
      end
   end

   // command to the flash array; the latched copy holds while busy so the
   // pointer is free for other use
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flash_cmd <= '0;
         flash_cmd_valid <= 1'b0;
      end else begin
         flash_cmd_valid <= 1'b0;
         if (store_take && op_q != OP_LOCKSET && (!flash_op || store_ok)) begin
            // buffer fills carry their own word index, so any order works
            flash_cmd <= '{op: op_q, page: z_page, word: z_word, data: store_data};
            flash_cmd_valid <= 1'b1;
         end
      end
   end

   // status pulses for stores that had no effect
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         store_ignored <= 1'b0;
         store_denied <= 1'b0;
      end else begin
         store_ignored <= store_program_memory_instr && !exec_boot;
         store_denied <= store_take && flash_op && !store_ok;
      end
   end

   // lock byte: bits may only go 1 to 0 except on chip erase
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lock_bits <= LOCK_RESET;
      end else if (chip_erase) begin
         lock_bits <= LOCK_RESET;
      end else if (prog_lock_we) begin
         lock_bits <= lock_bits & prog_lock_data;
      end else if (store_take && op_q == OP_LOCKSET) begin
         // pointer takes no part here; only data bits 5..0 program
         lock_bits <= lock_bits & (store_data[7:0] | LOCK_KEEP_MASK);
      end
   end

   // fuses: only the external programming port writes them
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fuse_bits <= FUSE_RESET;
      end else if (prog_fuse_we) begin
         fuse_bits <= prog_fuse_data;
      end
   end

   // reset vector follows the boot reset fuse
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         reset_vector <= APP_RESET_ADDR;
      end else begin
         reset_vector <= fuse_bits[FUSE_BOOT_RESET] ? APP_RESET_ADDR
                                                   : {boot_start, {WORD_IDX_W{1'b0}}};
      end
   end

   // program memory loads use the byte address, bit 0 picks the byte
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lpm_valid <= 1'b0;
         lpm_denied <= 1'b0;
         lpm_addr <= '0;
      end else begin
         lpm_valid <= lpm_strobe && read_ok;
         lpm_denied <= lpm_strobe && !read_ok;
         if (lpm_strobe) begin
            lpm_addr <= z;
         end
      end
   end

   // interrupt masking: only when vectors sit in the other section
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         irq_mask <= 1'b0;
      end else begin
         irq_mask <= (!exec_boot && ivsel_boot && app_irq)
                     || (exec_boot && !ivsel_boot && boot_irq);
      end
   end

   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_window;
      (state_q == ST_IDLE && ctrl_we) ##1 (!store_program_memory_instr) [*4]
         |=> !store_enable_bit;
   endproperty
   a_window: assert property (p_window) else $error("enable outlived window");

   property p_app_ignored;
      (state_q == ST_ARMED && store_program_memory_instr && !exec_boot)
         |=> !flash_cmd_valid && store_ignored;
   endproperty
   a_app_ignored: assert property (p_app_ignored) else $error("store from app acted");

   property p_app_block;
      (store_take && flash_op && !tgt_boot && !lock_bits[LOCK_APP_LO])
         |=> !flash_cmd_valid && store_denied;
   endproperty
   a_app_block: assert property (p_app_block) else $error("protected app store passed");

   property p_free_store;
      (store_take && flash_op && !tgt_boot && lock_bits[LOCK_APP_HI] && lock_bits[LOCK_APP_LO])
         |=> flash_cmd_valid && flash_cmd.page == $past(z_page) ##1 store_enable_bit;
   endproperty
   a_free_store: assert property (p_free_store) else $error("free store not issued");

   property p_lock_clear_only;
      !chip_erase |=> (lock_bits & ~$past(lock_bits)) == 8'h00;
   endproperty
   a_lock_clear_only: assert property (p_lock_clear_only) else $error("lock bit went to 1");

   property p_fuse_hold;
      !prog_fuse_we |=> $stable(fuse_bits);
   endproperty
   a_fuse_hold: assert property (p_fuse_hold) else $error("fuse changed");

   property p_reset_vec;
      fuse_bits[FUSE_BOOT_RESET] && $stable(fuse_bits) |=> reset_vector == APP_RESET_ADDR;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("bad reset vector");

   property p_boot_read_block;
      (lpm_strobe && !exec_boot && tgt_boot && !lock_bits[LOCK_BOOT_HI])
         |=> lpm_denied && !lpm_valid;
   endproperty
   a_boot_read_block: assert property (p_boot_read_block) else $error("boot read leaked");

   property p_lpm_byte;
      (lpm_strobe && read_ok) |=> lpm_valid && lpm_addr == $past(z);
   endproperty
   a_lpm_byte: assert property (p_lpm_byte) else $error("load address wrong");

   property p_latched;
      (state_q == ST_BUSY) |=> $stable(flash_cmd);
   endproperty
   a_latched: assert property (p_latched) else $error("command moved while busy");

   property p_irq;
      (!exec_boot && ivsel_boot && !lock_bits[LOCK_APP_HI]) |=> irq_mask;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not masked");

   c_erase: cover property (store_take && op_q == OP_ERASE ##[1:20] flash_done);
   c_fill: cover property (store_take && op_q == OP_FILL);
   c_lockset: cover property (store_take && op_q == OP_LOCKSET);
   c_lpm_deny: cover property (lpm_denied);
endmodule : fsp_ctrl

// file: design/fsp_lock_dec.sv
// decodes one two-bit protection field into access permissions
`timescale 1ns/1ps
module fsp_lock_dec (
   input wire logic [1:0] field,
   output logic store_ok,
   output logic cross_read_ok,
   output logic irq_gate
);
   // a bit at 1 is unprogrammed, 0 programmed; field is {high, low}
   always_comb begin
      store_ok = field[0];       // modes 11 and 01 let stores through
      cross_read_ok = field[1];  // modes 00 and 01 block cross-section loads
      irq_gate = ~field[1];      // high bit programmed masks interrupts
   end
endmodule : fsp_lock_dec

// file: dv/fsp_cpu_model.sv
// boot loader cpu core model with a flash array that answers erase and write
`timescale 1ns/1ps
module fsp_cpu_model (
   input wire logic clk_sys,
   input wire fsp_pkg::fsp_flash_cmd_type flash_cmd,
   input wire logic flash_cmd_valid,
   output logic [7:0] flash_pointer_high,
   output logic [7:0] flash_pointer_low,
   output logic ctrl_we,
   output fsp_pkg::fsp_op_type ctrl_op,
   output logic store_program_memory_instr,
   output logic [15:0] store_data,
   output logic lpm_strobe,
   output logic [14:0] pc_word,
   output logic ivsel_boot,
   output logic flash_done
);
   import fsp_pkg::*;
   // quiet bus at time zero
   initial begin
      {flash_pointer_high, flash_pointer_low} = 16'h0000;
      ctrl_we = 1'b0;
      ctrl_op = OP_FILL;
      store_program_memory_instr = 1'b0;
      store_data = 16'h0000;
      lpm_strobe = 1'b0;
      pc_word = 15'h0000;
      ivsel_boot = 1'b0;
      flash_done = 1'b0;
   end
   // program counter and vector placement seen by the block
   task automatic set_pc(input logic [14:0] pc, input logic iv);
      @(negedge clk_sys);
      pc_word = pc;
      ivsel_boot = iv;
   endtask : set_pc
   // control write then store after gap idle cycles; pointer reused afterwards
   task automatic op(input fsp_op_type o, input logic [15:0] z, input logic [15:0] d,
                     input logic [14:0] pc, input int gap);
      set_pc(pc, ivsel_boot);
      ctrl_we = 1'b1;
      ctrl_op = o;
      @(negedge clk_sys);
      ctrl_we = 1'b0;
      repeat (gap) @(negedge clk_sys);
      {flash_pointer_high, flash_pointer_low} = z;
      store_data = d;
      store_program_memory_instr = 1'b1;
      @(negedge clk_sys);
      store_program_memory_instr = 1'b0;
      {flash_pointer_high, flash_pointer_low} = ~z;
      store_data = ~d;
   endtask : op
   // program memory load from code at pc
   task automatic ld(input logic [15:0] z, input logic [14:0] pc);
      set_pc(pc, ivsel_boot);
      {flash_pointer_high, flash_pointer_low} = z;
      lpm_strobe = 1'b1;
      @(negedge clk_sys);
      lpm_strobe = 1'b0;
      {flash_pointer_high, flash_pointer_low} = ~z;
   endtask : ld
   // array busy for a few cycles, so the enable must stay up meanwhile
   always @(posedge clk_sys) begin
      if (flash_cmd_valid === 1'b1 && (flash_cmd.op === OP_ERASE || flash_cmd.op === OP_WRITE)) begin
         fork
            begin
               repeat (3) @(negedge clk_sys);
               flash_done = 1'b1;
               @(negedge clk_sys);
               flash_done = 1'b0;
            end
         join_none
      end
   end
endmodule : fsp_cpu_model

// file: dv/tb.sv
// self-checking testbench for the flash self-program protection block
`timescale 1ns/1ps
module tb;
   import fsp_pkg::*;
   localparam logic [14:0] BPC = 15'h7f00;
   localparam logic [14:0] APC = 15'h0010;
   localparam logic [15:0] ZA = 16'h1234;
   localparam logic [15:0] ZB = 16'hfe40;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] ph, pl, plk_d, pfu_d, lock_bits, fuse_bits;
   logic ctrl_we, store_program_memory_instr, lpm_strobe, ivsel_boot, flash_done, store_enable_bit;
   logic plk_we = 1'b0, pfu_we = 1'b0, chip_erase = 1'b0;
   logic flash_cmd_valid, store_ignored, store_denied, lpm_valid, lpm_denied, irq_mask;
   fsp_op_type ctrl_op;
   fsp_flash_cmd_type flash_cmd;
   logic [15:0] store_data, lpm_addr;
   logic [14:0] pc_word, reset_vector;
   logic [4:0] w;
   int mismatches = 0;
   int checks = 0;
   int tn = 0;
   always #2.5 clk_sys = ~clk_sys;
   fsp_ctrl u_dut (.clk_sys(clk_sys), .nrst(nrst), .flash_pointer_high(ph),
      .flash_pointer_low(pl), .ctrl_we(ctrl_we), .ctrl_op(ctrl_op),
      .store_program_memory_instr(store_program_memory_instr),
      .store_data(store_data), .lpm_strobe(lpm_strobe), .pc_word(pc_word),
      .ivsel_boot(ivsel_boot), .flash_done(flash_done), .prog_lock_we(plk_we),
      .prog_lock_data(plk_d), .prog_fuse_we(pfu_we), .prog_fuse_data(pfu_d),
      .chip_erase(chip_erase), .store_enable_bit(store_enable_bit), .flash_cmd(flash_cmd),
      .flash_cmd_valid(flash_cmd_valid), .store_ignored(store_ignored),
      .store_denied(store_denied),
      .lpm_valid(lpm_valid), .lpm_addr(lpm_addr), .lpm_denied(lpm_denied),
      .irq_mask(irq_mask), .reset_vector(reset_vector), .lock_bits(lock_bits),
      .fuse_bits(fuse_bits));
   fsp_cpu_model u_cpu (.clk_sys(clk_sys), .flash_cmd(flash_cmd),
      .flash_cmd_valid(flash_cmd_valid), .flash_pointer_high(ph), .flash_pointer_low(pl),
      .ctrl_we(ctrl_we), .ctrl_op(ctrl_op),
      .store_program_memory_instr(store_program_memory_instr), .store_data(store_data),
      .lpm_strobe(lpm_strobe), .pc_word(pc_word), .ivsel_boot(ivsel_boot),
      .flash_done(flash_done));
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict
   // wide enough for the whole flash command word
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // store outcome half a cycle after the taking edge: valid, denied, ignored
   // the store call returns on the falling edge right after the taking edge,
   // the only falling edge at which these one-cycle pulses stand
   task automatic st(input logic [2:0] e);
      chk({flash_cmd_valid, store_denied, store_ignored}, e);
   endtask : st
   // load outcome: granted flag, refused flag, and address when granted
   task automatic ldc(input logic [15:0] z, input logic [14:0] pc, input logic [1:0] e);
      u_cpu.ld(z, pc);
      chk({lpm_valid, lpm_denied}, e);
      if (e[1]) chk(lpm_addr, z);
   endtask : ldc
   // bounded wait for the store window or array operation to finish
   task automatic wait_idle();
      int i;
      for (i = 0; i < 20 && store_enable_bit !== 1'b0; i++) @(negedge clk_sys);
      if (store_enable_bit !== 1'b0) begin
         mismatches++;
         print_verdict();
      end
   endtask : wait_idle
   // external programming port: 0 lock write, 1 fuse write, 2 chip erase
   task automatic prog(input int k, input logic [7:0] d);
      @(negedge clk_sys);
      plk_d = d;
      pfu_d = d;
      {chip_erase, pfu_we, plk_we} = 3'h1 << k;
      @(negedge clk_sys);
      {chip_erase, pfu_we, plk_we} = 3'h0;
      @(negedge clk_sys);
   endtask : prog
   task automatic endt();
      tn++;
      $display("test %0d done", tn);
   endtask : endt
   initial begin
      plk_d = 8'h00;
      pfu_d = 8'h00;
      repeat (6) @(negedge clk_sys);
      nrst = 1'b1;
      @(negedge clk_sys);
      chk(lock_bits, 8'hff);
      chk(reset_vector, 15'h0000);
      endt();
      // general lock programmed, fills out of order, then erase and write one page
      prog(0, 8'hfc);
      for (int k = 0; k < 2; k++) begin
         w = k ? 5'h01 : 5'h1f;
         u_cpu.op(OP_FILL, {10'h048, w, 1'b1}, 16'ha5a5, BPC, 0);
         st(3'h4);
         chk(flash_cmd, {2'h0, 10'h048, w, 16'ha5a5});
         wait_idle();
      end
      ldc(ZA, BPC, 2'h2);
      u_cpu.op(OP_ERASE, ZA, 16'h0000, BPC, 3);
      st(3'h4);
      chk(flash_cmd.page, 10'h048);
      wait_idle();
      u_cpu.op(OP_WRITE, ZA, 16'h0000, BPC, 0);
      st(3'h4);
      wait_idle();
      endt();
      // store from application code, then a store that misses the window
      u_cpu.op(OP_FILL, ZA, 16'h1111, APC, 0);
      st(3'h1);
      wait_idle();
      u_cpu.op(OP_FILL, ZA, 16'h1111, BPC, 4);
      st(3'h0);
      chk(store_enable_bit, 1'b0);
      endt();
      // application field 10
      prog(2, 8'h00);
      prog(0, 8'hfb);
      u_cpu.op(OP_ERASE, ZA, 16'h0000, BPC, 0);
      st(3'h2);
      wait_idle();
      endt();
      // application 01, boot 10
      prog(2, 8'h00);
      chk(lock_bits, 8'hff);
      prog(0, 8'he7);
      u_cpu.op(OP_ERASE, ZA, 16'h0000, BPC, 0);
      st(3'h4);
      wait_idle();
      u_cpu.op(OP_ERASE, ZB, 16'h0000, BPC, 0);
      st(3'h2);
      wait_idle();
      ldc(ZA, BPC, 2'h1);
      ldc(ZB | 16'h0001, APC, 2'h2);
      u_cpu.set_pc(APC, 1'b1);
      repeat (2) @(negedge clk_sys);
      chk(irq_mask, 1'b1);
      endt();
      // lock set by store with a stray pointer: both fields 00
      prog(2, 8'h00);
      u_cpu.op(OP_LOCKSET, 16'h5a5a, 16'h0003, BPC, 0);
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk(lock_bits, 8'hc3);
      wait_idle();
      ldc(ZB, APC, 2'h1);
      ldc(ZA, BPC, 2'h1);
      u_cpu.op(OP_ERASE, ZB, 16'h0000, BPC, 0);
      st(3'h2);
      wait_idle();
      u_cpu.op(OP_WRITE, ZA, 16'h0000, BPC, 0);
      st(3'h2);
      wait_idle();
      u_cpu.set_pc(BPC, 1'b0);
      repeat (2) @(negedge clk_sys);
      chk(irq_mask, 1'b1);
      endt();
      // boot reset fuse programmed from the external port only
      chk(fuse_bits, 8'hff);
      prog(1, 8'hfe);
      chk(fuse_bits, 8'hfe);
      chk(reset_vector, 15'h7f00);
      // smaller size codes move the boundary down; both fields are still 00
      prog(1, 8'hf8);
      chk(reset_vector, 15'h7800);
      ldc(ZA, 15'h77e0, 2'h2);
      ldc(ZA, 15'h7800, 2'h1);
      prog(1, 8'hfa);
      chk(reset_vector, 15'h7c00);
      prog(1, 8'hfc);
      chk(reset_vector, 15'h7e00);
      endt();
      print_verdict();
   end
endmodule : tb

// file: shared/fsp_pkg.sv
// shared constants and types for the flash self-program protection block
package fsp_pkg;
   localparam int PTR_W = 16;
   localparam int WORD_IDX_W = 5;
   localparam int PAGE_W = 10;
   localparam int WORD_ADDR_W = 15;
   // enable window length in clock cycles
   localparam logic [2:0] ENABLE_WINDOW = 3'h4;
   // lock byte layout: general lock, application field, boot field
   localparam int LOCK_GEN_LO = 0;
   localparam int LOCK_GEN_HI = 1;
   localparam int LOCK_APP_LO = 2;
   localparam int LOCK_APP_HI = 3;
   localparam int LOCK_BOOT_LO = 4;
   localparam int LOCK_BOOT_HI = 5;
   localparam logic [7:0] LOCK_RESET = 8'hff;
   localparam logic [7:0] LOCK_KEEP_MASK = 8'hc0;
   // fuse byte layout: boot reset fuse and boot section size code
   localparam int FUSE_BOOT_RESET = 0;
   localparam int FUSE_SIZE_LO = 1;
   localparam int FUSE_SIZE_HI = 2;
   localparam logic [7:0] FUSE_RESET = 8'hff;
   localparam logic [WORD_ADDR_W-1:0] APP_RESET_ADDR = 15'h0000;
   // first boot page for each size code
   localparam logic [PAGE_W-1:0] BOOT_START_0 = 10'h3c0;
   localparam logic [PAGE_W-1:0] BOOT_START_1 = 10'h3e0;
   localparam logic [PAGE_W-1:0] BOOT_START_2 = 10'h3f0;
   localparam logic [PAGE_W-1:0] BOOT_START_3 = 10'h3f8;

   typedef enum {ST_IDLE, ST_ARMED, ST_BUSY} fsp_state_type;
   typedef enum logic [1:0] {OP_FILL, OP_ERASE, OP_WRITE, OP_LOCKSET} fsp_op_type;

   typedef struct packed {
      fsp_op_type op;
      logic [PAGE_W-1:0] page;
      logic [WORD_IDX_W-1:0] word;
      logic [15:0] data;
   } fsp_flash_cmd_type;
endpackage : fsp_pkg
